/* File: design/fmp_pkg.sv */
/*
 * fmp_pkg: shared constants and types for the keyed flash mode register bank.
 * assumes: an 8-bit peripheral store path with a 16-bit store address.
 */
package fmp_pkg;
    // ------------------------------------------------------------
    // register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_MODE_CTRL = 16'hffc4;
    localparam logic [15:0] ADDR_KEY       = 16'hffc0;
    localparam logic [15:0] ADDR_STATUS    = 16'hffc2;

    // ------------------------------------------------------------
    // values and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] KEY_VALUE       = 8'ha5;
    localparam logic [7:0] RST_USER        = 8'h08;
    localparam logic [7:0] RST_ONBOARD     = 8'h0c;
    localparam logic [7:0] RST_STATUS      = 8'h00;
    localparam logic [7:0] ZERO_BYTE       = 8'h00;
    localparam int         BIT_WE_DIS      = 3;
    localparam int         BIT_PIN_LVL     = 2;
    localparam int         BIT_SPM_HI      = 1;
    localparam int         BIT_SPM_LO      = 0;
    localparam int         BIT_SEQ_ERR     = 0;
    localparam logic [3:0] MODE_CTRL_MASK  = 4'hf;
    localparam logic [15:0] FW_ENTRY_ADDR  = 16'h8100;

    typedef enum logic [1:0] {
        FMP_SPM_NORMAL = 2'b00,
        FMP_SPM_A1     = 2'b01,
        FMP_SPM_BAD    = 2'b10,
        FMP_SPM_A2     = 2'b11
    } fmp_spm_t;

    // one cpu store to the peripheral space
    typedef struct packed {
        logic        valid;
        logic        fw;     // store issued by firmware
        logic [15:0] addr;
        logic [7:0]  data;
    } fmp_store_t;
endpackage

/* File: design/fmp_regs.sv */
/*
 * fmp_regs: mode control, key and status registers for flash self-programming.
 * assumes: cpu stores arrive one per cycle; reads are combinational-free, taken
 * from the registered read port one cycle after the read request.
 */
`timescale 1ns/100ps
`default_nettype none
// Operation
// - reset mode register to 08H in user mode, 0CH on-board.
// - bit 2 reflects mode pin level, read-only.
// - writing/erasing allowed only when disable bit 0 and pin bit 1.
// - mode field 00 normal, 01 A1 call 8100H, 11 A2 firmware fetch, 10 prohibited; the code commits 10 like any other value.
// - mode A2 can only be entered by firmware.
// - on-board programming mode ignores the self-programming mode field.
// - upper mode bit selects cpu address or firmware-set address.
// - mode register committed only by fourth store of keyed sequence.
// - failed sequence leaves register unchanged and raises error flag.
// - key store with value other than A5H raises error.
// - store to other register during sequence raises error.
// - third store not inverse of second raises error.
// - fourth store differing from second raises error.
// - error flag sticky in status bit 0, cleared by written 0, resets 00H.
// - key register has no reset value.
module fmp_regs (
    input  wire logic              mclk_in,        // system clock, 200 MHz
    input  wire logic              resetn_in,      // async reset, active low
    input  wire logic              onboard_in,     // device in on-board programming mode
    input  wire logic              flash_mode_pin_in, // mode pin level
    input  wire fmp_pkg::fmp_store_t st_in,        // cpu store
    input  wire logic              rd_in,          // read request
    input  wire logic [15:0]       rd_addr_in,     // read address
    input  wire logic [15:0]       cpu_addr_in,    // cpu flash address
    input  wire logic [15:0]       fw_addr_in,     // firmware flash address
    output logic [7:0]             rd_data_out,    // read data
    output logic [7:0]             flash_mode_control_out, // mode register
    output logic                   flash_we_ok_out, // write/erase permitted
    output logic                   fetch_fw_out,   // fetch from firmware rom
    output logic                   fw_call_ok_out, // firmware entry call allowed
    output logic [15:0]            flash_addr_out, // selected flash address
    output logic                   protect_sequence_error_out // sticky error flag
);
    logic       commit;
    logic [7:0] commit_val;
    logic       viol;
    logic [3:0] ctrl;         // bits 3..0 of mode register, bit 2 unused here
    logic       pin_lvl;
    logic       boot_done;
    logic       err;
    logic       err_clr;
    logic       commit_fw;
    logic [1:0] next_spm;
    logic [7:0] mode_view;

    fmp_seq u_seq (
        .mclk_in    (mclk_in),
        .resetn_in  (resetn_in),
        .st_in      (st_in),
        .commit_out (commit),
        .value_out  (commit_val),
        .viol_out   (viol)
    );

    // ------------------------------------------------------------
    // mode control register
    // ------------------------------------------------------------
    // firmware marker of the fourth store, aligned with the commit pulse
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            commit_fw <= 1'b0;
        end else begin
            commit_fw <= st_in.valid && st_in.fw;
        end
    end

    // user software asking for A2 keeps the old field rather than half-applying
    always_comb begin
        next_spm = commit_val[fmp_pkg::BIT_SPM_HI:fmp_pkg::BIT_SPM_LO];
        if (next_spm == fmp_pkg::FMP_SPM_A2 && !commit_fw) begin
            next_spm = ctrl[fmp_pkg::BIT_SPM_HI:fmp_pkg::BIT_SPM_LO];
        end
    end

    // reset value depends on a strap, so it is loaded on the first clock after release
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ctrl      <= fmp_pkg::RST_USER[3:0];
            boot_done <= 1'b0;
        end else if (!boot_done) begin
            boot_done <= 1'b1;
            ctrl      <= onboard_in ? fmp_pkg::RST_ONBOARD[3:0]
                                    : fmp_pkg::RST_USER[3:0];
        end else if (commit) begin
            ctrl[fmp_pkg::BIT_WE_DIS] <= commit_val[fmp_pkg::BIT_WE_DIS];
            ctrl[fmp_pkg::BIT_SPM_HI:fmp_pkg::BIT_SPM_LO] <= next_spm;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_lvl <= 1'b0;
        end else begin
            pin_lvl <= flash_mode_pin_in;
        end
    end

    always_comb begin
        mode_view = fmp_pkg::ZERO_BYTE;
        mode_view[3:0] = ctrl & fmp_pkg::MODE_CTRL_MASK;
        mode_view[fmp_pkg::BIT_PIN_LVL] = pin_lvl;
    end

    // ------------------------------------------------------------
    // status register
    // ------------------------------------------------------------
    assign err_clr = st_in.valid && st_in.addr == fmp_pkg::ADDR_STATUS
                     && !st_in.data[fmp_pkg::BIT_SEQ_ERR];

    // set wins over a clear in the same cycle
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            err <= fmp_pkg::RST_STATUS[fmp_pkg::BIT_SEQ_ERR];
        end else if (viol) begin
            err <= 1'b1;
        end else if (err_clr) begin
            err <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // outputs and read port
    // ------------------------------------------------------------
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            flash_mode_control_out     <= fmp_pkg::RST_USER;
            flash_we_ok_out            <= 1'b0;
            fetch_fw_out               <= 1'b0;
            fw_call_ok_out             <= 1'b0;
            flash_addr_out             <= '0;
            protect_sequence_error_out <= 1'b0;
            rd_data_out                <= fmp_pkg::ZERO_BYTE;
        end else begin
            flash_mode_control_out     <= mode_view;
            flash_we_ok_out            <= !ctrl[fmp_pkg::BIT_WE_DIS] && pin_lvl;
            fetch_fw_out   <= !onboard_in
                && ctrl[1:0] == fmp_pkg::FMP_SPM_A2;
            fw_call_ok_out <= !onboard_in
                && ctrl[1:0] == fmp_pkg::FMP_SPM_A1;
            flash_addr_out <= (!onboard_in && ctrl[fmp_pkg::BIT_SPM_HI])
                ? fw_addr_in : cpu_addr_in;
            protect_sequence_error_out <= err;
            rd_data_out <= fmp_pkg::ZERO_BYTE;
            if (rd_in && rd_addr_in == fmp_pkg::ADDR_MODE_CTRL) begin
                rd_data_out <= mode_view;
            end else if (rd_in && rd_addr_in == fmp_pkg::ADDR_STATUS) begin
                rd_data_out[fmp_pkg::BIT_SEQ_ERR] <= err;
            end
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_reset_value: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (!boot_done) |=> ctrl == (onboard_in ? fmp_pkg::RST_ONBOARD[3:0]
                                             : fmp_pkg::RST_USER[3:0])
                         || $past(onboard_in) != onboard_in)
        else $error("wrong mode reset value");
    chk_pin_bit: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        ##1 flash_mode_control_out[fmp_pkg::BIT_PIN_LVL] == $past(pin_lvl))
        else $error("pin bit does not follow pin");
    chk_we_gate: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        ##1 flash_we_ok_out == (!$past(ctrl[fmp_pkg::BIT_WE_DIS]) && $past(pin_lvl)))
        else $error("write enable does not follow gate");
    chk_no_user_a2: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (commit && !commit_fw && ctrl[1:0] != fmp_pkg::FMP_SPM_A2)
        |=> ctrl[1:0] != fmp_pkg::FMP_SPM_A2)
        else $error("user entered mode A2");
    chk_onboard_ignore: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        onboard_in ##1 onboard_in |-> !fetch_fw_out && !fw_call_ok_out)
        else $error("mode field acted on-board");
    chk_ctrl_stable: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (boot_done && !commit) |=> $stable(ctrl))
        else $error("mode register changed without commit");
    chk_err_sticky: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (err && !err_clr) |=> err)
        else $error("error flag dropped");
    chk_viol_sets: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        viol |=> err)
        else $error("violation did not set flag");
endmodule // fmp_regs
`default_nettype wire

/* File: design/fmp_seq.sv */
/*
 * fmp_seq: unlock tracker for the keyed four-store mode register update.
 * assumes: one store per cycle at most, peripheral stores only.
 */
`timescale 1ns/100ps
`default_nettype none
module fmp_seq (
    input  wire logic              mclk_in,     // system clock
    input  wire logic              resetn_in,   // async reset, active low
    input  wire fmp_pkg::fmp_store_t st_in,     // store request
    output logic                   commit_out,  // fourth store accepted
    output logic [7:0]             value_out,   // value to commit
    output logic                   viol_out     // sequence violation pulse
);
    typedef enum logic [1:0] {FMP_IDLE, FMP_KEYED, FMP_FIRST, FMP_INV} fmp_seq_t;
    fmp_seq_t   state;
    logic [7:0] held;
    logic       to_ctrl;
    logic       to_key;

    assign to_ctrl = st_in.valid && (st_in.addr == fmp_pkg::ADDR_MODE_CTRL);
    assign to_key  = st_in.valid && (st_in.addr == fmp_pkg::ADDR_KEY);

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state      <= FMP_IDLE;
            commit_out <= 1'b0;
            viol_out   <= 1'b0;
        end else begin
            commit_out <= 1'b0;
            viol_out   <= 1'b0;
            if (st_in.valid) begin
                case (state)
                    FMP_IDLE: begin
                        if (to_key && st_in.data == fmp_pkg::KEY_VALUE) begin
                            state <= FMP_KEYED;
                        end else if (to_key || to_ctrl) begin
                            viol_out <= 1'b1;
                        end
                    end
                    FMP_KEYED: begin
                        state <= to_ctrl ? FMP_FIRST : FMP_IDLE;
                        viol_out <= !to_ctrl;
                    end
                    FMP_FIRST: begin
                        state <= (to_ctrl && st_in.data == ~held) ? FMP_INV : FMP_IDLE;
                        viol_out <= !(to_ctrl && st_in.data == ~held);
                    end
                    FMP_INV: begin
                        state <= FMP_IDLE;
                        if (to_ctrl && st_in.data == held) begin
                            commit_out <= 1'b1;
                        end else begin
                            viol_out <= 1'b1;
                        end
                    end
                    default: state <= FMP_IDLE;
                endcase
            end
        end
    end

    // key register itself holds no reset value; only the captured target matters
    always_ff @(posedge mclk_in) begin
        if (state == FMP_KEYED && to_ctrl) begin
            held <= st_in.data;
        end
    end

    assign value_out = held;

    chk_commit_needs_key: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        commit_out |-> $past(state) == FMP_INV) else $error("commit without sequence");
    chk_bad_key_error: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (state == FMP_IDLE && to_key && st_in.data != fmp_pkg::KEY_VALUE) |=> viol_out)
        else $error("bad key not flagged");
    chk_keyed_other_error: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (state == FMP_KEYED && st_in.valid && !to_ctrl) |=> viol_out && state == FMP_IDLE)
        else $error("foreign store after key not flagged");
    chk_inverse_error: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (state == FMP_FIRST && to_ctrl && st_in.data != ~held) |=> viol_out)
        else $error("non-inverse third store not flagged");
    chk_fourth_mismatch: assert property (@(posedge mclk_in) disable iff (!resetn_in)
        (state == FMP_INV && to_ctrl && st_in.data != held) |=> viol_out && !commit_out)
        else $error("fourth mismatch not flagged");
endmodule // fmp_seq
`default_nettype wire

/* File: verif/fmp_cpu_model.sv */
/*
 * fmp_cpu_model: software-side store source for the keyed mode register bank.
 * assumes: driven through its tasks by the bench; one store per clock at most.
 */
`timescale 1ns/100ps
`default_nettype none
module fmp_cpu_model (
    input  wire logic              mclk_in, // system clock
    output var fmp_pkg::fmp_store_t st_out  // store toward the registers
);
    fmp_pkg::fmp_store_t last;

    initial begin
        st_out = '0;
        last   = '0;
    end

    task automatic store(input logic [15:0] a, input logic [7:0] d, input logic fw);
        @(posedge mclk_in);
        #1;
        st_out = {1'b1, fw, a, d};
        last   = st_out;
    endtask

    // idle bus shows the inverse of the last store so stale data never matches
    task automatic release_bus();
        @(posedge mclk_in);
        #1;
        st_out = {1'b0, last.fw, ~last.addr, ~last.data};
    endtask

    // flaw: 0 clean, 1 bad key, 2/5 foreign store at step 2/3, 3 bad inverse, 4 bad repeat
    task automatic unlock(input logic [7:0] v, input logic fw, input int flaw);
        store(fmp_pkg::ADDR_KEY, (flaw == 1) ? ~fmp_pkg::KEY_VALUE : fmp_pkg::KEY_VALUE, fw);
        store((flaw == 2) ? fmp_pkg::ADDR_STATUS : fmp_pkg::ADDR_MODE_CTRL,
              (flaw == 2) ? 8'h01 : v, fw);
        store((flaw == 5) ? fmp_pkg::ADDR_STATUS : fmp_pkg::ADDR_MODE_CTRL,
              (flaw == 5) ? 8'h01 : ((flaw == 3) ? v : ~v), fw);
        store(fmp_pkg::ADDR_MODE_CTRL, (flaw == 4) ? (v ^ 8'h01) : v, fw);
        release_bus();
    endtask
endmodule // fmp_cpu_model
`default_nettype wire

/* File: verif/testbench.sv */
/*
 * testbench: self-checking bench for fmp_regs with a software store model.
 * assumes: fmp_pkg and the design files compiled first; 200 MHz clock.
 */
`timescale 1ns/100ps
`default_nettype none
`define CHK(got, exp, what) begin cmp_count++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp); end end
module testbench;
    logic mclk = 1'b0, resetn = 1'b0, onboard = 1'b0, pin = 1'b0, rd = 1'b0;
    logic [15:0] rd_addr = 16'h0000, cpu_addr = 16'h0000, fw_addr = 16'h0000, faddr;
    logic [7:0] rdata, mode_out, m_exp, v;
    logic we_ok, fetch_fw, fw_call, err_out, err_exp, fw;
    logic [31:0] r;
    fmp_pkg::fmp_store_t st;
    integer seed = 32'h0000_568c;
    int fails = 0, cmp_count = 0, cycles = 0;

    always #2.5 mclk = ~mclk;

    fmp_cpu_model cpu (.mclk_in(mclk), .st_out(st));
    fmp_regs dut (.mclk_in(mclk), .resetn_in(resetn), .onboard_in(onboard),
        .flash_mode_pin_in(pin), .st_in(st), .rd_in(rd), .rd_addr_in(rd_addr),
        .cpu_addr_in(cpu_addr), .fw_addr_in(fw_addr), .rd_data_out(rdata),
        .flash_mode_control_out(mode_out), .flash_we_ok_out(we_ok), .fetch_fw_out(fetch_fw),
        .fw_call_ok_out(fw_call), .flash_addr_out(faddr), .protect_sequence_error_out(err_out));

    function automatic logic [7:0] view();
        return {4'h0, m_exp[3], pin, m_exp[1:0]};
    endfunction

    // a user commit asking for firmware fetch keeps the old mode field
    function automatic logic [7:0] next_mode(input logic [7:0] old, input logic [7:0] nv,
                                             input logic nfw);
        return {4'h0, nv[3], 1'b0, (nv[1:0] == 2'b11 && !nfw) ? old[1:0] : nv[1:0]};
    endfunction

    task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk);
        #1;
        rd = 1'b1;
        rd_addr = a;
        @(posedge mclk);
        #1;
        rd = 1'b0;
        rd_addr = ~a;
        d = rdata;
    endtask

    task automatic settle_store(input logic [15:0] a, input logic [7:0] d);
        cpu.store(a, d, 1'b0);
        cpu.release_bus();
        repeat (4) @(posedge mclk);
        #1;
    endtask

    task automatic check_all(input string name);
        logic [7:0] d;
        #1;
        `CHK(mode_out, view(), "mode view")
        `CHK(we_ok, !m_exp[3] && pin, "write enable")
        `CHK(fetch_fw, m_exp[1:0] == 2'b11 && !onboard, "rom fetch")
        `CHK(fw_call, m_exp[1:0] == 2'b01 && !onboard, "entry call")
        `CHK(faddr, (m_exp[1] && !onboard) ? fw_addr : cpu_addr, "flash addr")
        `CHK(err_out, err_exp, "error flag")
        rd_reg(fmp_pkg::ADDR_MODE_CTRL, d);
        `CHK(d, view(), "mode read")
        rd_reg(fmp_pkg::ADDR_STATUS, d);
        `CHK(d, {7'h00, err_exp}, "status read")
        rd_reg(16'h1234, d);
        `CHK(d, fmp_pkg::ZERO_BYTE, "unmapped read")
        $display("test %s done", name);
    endtask

    task automatic do_reset(input logic ob, input logic pn);
        resetn = 1'b0;
        onboard = ob;
        pin = pn;
        m_exp = ob ? fmp_pkg::RST_ONBOARD : fmp_pkg::RST_USER;
        err_exp = 1'b0;
        repeat (6) @(posedge mclk);
        #1;
        resetn = 1'b1;
        repeat (4) @(posedge mclk);
        check_all(ob ? "reset onboard" : "reset user");
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            close_out();
        end
    end

    initial begin
        do_reset(1'b0, 1'b0);
        for (int i = 0; i < 24; i++) begin
            r = $random(seed);
            v = r[7:0];
            fw = r[8];
            pin = r[9];
            cpu_addr = r[31:16];
            r = $random(seed);
            fw_addr = r[15:0];
            if (v[1:0] == 2'b10)
                v[0] = 1'b1;
            if (i < 2) begin
                v = 8'h03;
                fw = i[0];
            end
            cpu.unlock(v, fw, 0);
            m_exp = next_mode(m_exp, v, fw);
            repeat (4) @(posedge mclk);
            check_all("commit");
        end
        for (int f = 1; f <= 5; f++) begin
            cpu.unlock(m_exp ^ 8'h09, 1'b0, f);
            err_exp = 1'b1;
            repeat (4) @(posedge mclk);
            check_all("violation");
            settle_store(fmp_pkg::ADDR_STATUS, 8'h01);
            `CHK(err_out, 1'b1, "flag after write one")
            settle_store(fmp_pkg::ADDR_STATUS, 8'h00);
            err_exp = 1'b0;
            check_all("flag clear");
        end
        cpu.unlock(8'h08, 1'b0, 0);
        m_exp = next_mode(m_exp, 8'h08, 1'b0);
        settle_store(fmp_pkg::ADDR_MODE_CTRL, 8'h01);
        err_exp = 1'b1;
        check_all("reuse of key");
        do_reset(1'b1, 1'b1);
        cpu.unlock(8'h03, 1'b1, 0);
        m_exp = next_mode(m_exp, 8'h03, 1'b1);
        repeat (4) @(posedge mclk);
        check_all("onboard ignores mode");
        close_out();
    end
endmodule // testbench
`default_nettype wire
